//--- rtl/tsc_pkg.sv
// Purpose: Shared constants and types for the tx supply and clock start-up block
// Assumes: Wishbone byte addresses; register byte address is four times its index
// Notes:   Timing counts derive from the 40 MHz system clock
package tsc_pkg;
   // ----------------------------------------------------------
   // Register indices
   // ----------------------------------------------------------
   localparam int          ADR_W         = 13;
   localparam logic [10:0] IDX_TXREG     = 11'h002;
   localparam logic [10:0] IDX_AMP_NOM   = 11'h006;
   localparam logic [10:0] IDX_AMP_RDR   = 11'h007;
   localparam logic [10:0] IDX_AMP_CARD  = 11'h008;
   localparam logic [10:0] IDX_BOOST     = 11'h009;
   localparam logic [10:0] IDX_OSC_CFG   = 11'h00f;
   localparam logic [10:0] IDX_OSC_TMO   = 11'h010;
   localparam logic [10:0] IDX_PLL_REF   = 11'h011;
   localparam logic [10:0] IDX_RETRY     = 11'h012;
   localparam logic [10:0] IDX_DISCH     = 11'h50d;
   localparam logic [10:0] IDX_STATUS    = 11'h020;
   localparam logic [10:0] IDX_MASK      = 11'h021;
   localparam logic [10:0] IDX_STATE     = 11'h022;
   // ----------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------
   localparam int TXREG_EN_BIT  = 0;
   localparam int TXREG_OCP_BIT = 1;
   localparam int RECAL_BIT     = 0;
   localparam int RETRY_MSB     = 7;
   localparam int RETRY_LSB     = 5;
   localparam int IVL_MSB       = 4;
   localparam int IVL_LSB       = 0;
   localparam int REF_MSB       = 3;
   localparam int DISCH_BIT     = 0;
   localparam int ST_CLKERR     = 0;
   localparam int ST_TMO        = 1;
   localparam int ST_LOCK       = 2;
   localparam int ST_DISCH      = 3;
   localparam int ST_W          = 4;
   // ----------------------------------------------------------
   // Reset values and codes
   // ----------------------------------------------------------
   localparam logic [1:0]  RST_TXREG      = 2'h0;
   localparam logic [7:0]  RST_BYTE       = 8'h00;
   localparam logic [7:0]  RST_DISCH      = 8'h01;
   localparam logic [7:0]  AMP_CODE_MAX   = 8'h2a;
   localparam logic [7:0]  AMP_CODE_MIN   = 8'h00;
   localparam logic [7:0]  BOOST_CODE_MAX = 8'h1d;
   localparam logic [3:0]  REF_48M        = 4'h5;
   localparam logic [3:0]  REF_HFO        = 4'h7;
   localparam logic [3:0]  REF_XTAL       = 4'h8;
   // ----------------------------------------------------------
   // Timing
   // ----------------------------------------------------------
   localparam int CLK_KHZ      = 40000;
   localparam int OSC_STEP_US  = 128;
   localparam int OSC_STEP_CYC = OSC_STEP_US * CLK_KHZ / 1000;
   localparam int CARRIER_KHZ  = 13560;
   localparam int IVL_PERIODS  = 256;
   localparam int IVL_STEP_CYC = (IVL_PERIODS * CLK_KHZ + CARRIER_KHZ - 1) / CARRIER_KHZ;
   localparam int DISCH_HI_CYC = 40;
   // ----------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------
   typedef struct packed {
      logic       recal_en;
      logic [7:0] timeout;
      logic [2:0] max_retry;
      logic [4:0] interval;
   } tsc_osc_cfg_t;
   typedef struct packed {
      logic locked;
      logic tmo;
      logic clk_err;
   } tsc_evt_t;
endpackage

//--- rtl/tsc_lock_seq.sv
// Purpose: Oscillator start-up and PLL lock retry sequencer
// Assumes: Inputs synchronous to clk_i
// Notes:   Events and requests are one-cycle pulses, save lock requests, which can fall on consecutive cycles when interval is 0
`timescale 1ns/1ps
module tsc_lock_seq #(
   parameter int STEP_CYC = tsc_pkg::OSC_STEP_CYC,
   parameter int IVL_CYC  = tsc_pkg::IVL_STEP_CYC
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 wake_i,
   input  wire tsc_pkg::tsc_osc_cfg_t cfg_i,
   input  wire logic                 osc_ready_i,
   input  wire logic                 pll_locked_i,
   output logic                      recal_o,
   output logic                      lock_req_o,
   output tsc_pkg::tsc_evt_t         evt_o,
   output logic [1:0]                state_o,
   output logic [2:0]                retry_o
);
   typedef enum logic [1:0] {S_IDLE, S_OSC, S_LOCK} tsc_seq_t;
   tsc_seq_t    st_reg;
   logic [23:0] cyc_reg;
   logic [7:0]  step_reg;
   logic [2:0]  retry_reg;
   logic        tick;
   logic        ivl_done;

   assign tick     = (st_reg == S_OSC) ? (cyc_reg == 24'(STEP_CYC - 1))
                                       : (cyc_reg == 24'(IVL_CYC - 1));
   assign ivl_done = step_reg >= {3'h0, cfg_i.interval};
   assign state_o  = st_reg;
   assign retry_o  = retry_reg;

   always_ff @(posedge clk_i)
   begin
      // Restart the count at lock entry so the first interval is whole
      if (rst_i || st_reg == S_IDLE || tick || (st_reg == S_OSC && osc_ready_i))
         cyc_reg <= 24'h0;
      else
         cyc_reg <= cyc_reg + 24'h1;
   end

   always_ff @(posedge clk_i)
   begin
      recal_o    <= 1'b0;
      lock_req_o <= 1'b0;
      evt_o      <= '0;
      if (rst_i)
      begin
         st_reg    <= S_IDLE;
         step_reg  <= 8'h00;
         retry_reg <= 3'h0;
      end
      else
      begin
         unique case (st_reg)
            S_IDLE:
            if (wake_i)
            begin
               recal_o   <= cfg_i.recal_en;
               st_reg    <= S_OSC;
               step_reg  <= 8'h00;
               retry_reg <= 3'h0;
            end
            S_OSC:
            if (osc_ready_i)
            begin
               st_reg     <= S_LOCK;
               step_reg   <= 8'h00;
               lock_req_o <= 1'b1;
            end
            else if (step_reg >= cfg_i.timeout)
            begin
               evt_o.tmo <= 1'b1;
               st_reg    <= S_IDLE;
            end
            else if (tick)
               step_reg <= step_reg + 8'h01;
            S_LOCK:
            if (ivl_done)
            begin
               step_reg <= 8'h00;
               if (pll_locked_i)
               begin
                  evt_o.locked <= 1'b1;
                  st_reg       <= S_IDLE;
               end
               else if (retry_reg == cfg_i.max_retry)
               begin
                  evt_o.clk_err <= 1'b1;
                  st_reg        <= S_IDLE;
               end
               else
               begin
                  retry_reg  <= retry_reg + 3'h1;
                  lock_req_o <= 1'b1;
               end
            end
            else if (tick)
               step_reg <= step_reg + 8'h01;
            default:
               st_reg <= S_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------
   // Checks
   // ----------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_recal;
      (st_reg == S_IDLE && wake_i) |=> (recal_o == $past(cfg_i.recal_en));
   endproperty
   a_recal: assert property (p_recal) else $error("recal pulse mismatch");
   property p_tmo_bound;
      (st_reg == S_OSC) |-> (step_reg <= cfg_i.timeout);
   endproperty
   a_tmo_bound: assert property (p_tmo_bound) else $error("timeout overrun");
   property p_err_budget;
      evt_o.clk_err |-> ($past(retry_reg) == $past(cfg_i.max_retry) && !$past(pll_locked_i));
   endproperty
   a_err_budget: assert property (p_err_budget) else $error("early clock error");
   property p_req_gap;
      (lock_req_o && cfg_i.interval != 5'h0) |=> !lock_req_o;
   endproperty
   a_req_gap: assert property (p_req_gap) else $error("lock requests too close");
endmodule

//--- rtl/tsc_top.sv
// Purpose: Tx supply and oscillator start-up configuration bank with Wishbone slave
// Assumes: Classic Wishbone, byte addresses, register index = adr_i[12:2]
// Notes:   One-cycle ack; unmapped addresses ack with zero data
`timescale 1ns/1ps
module tsc_top #(
   parameter int OSC_STEP_CYC = tsc_pkg::OSC_STEP_CYC,
   parameter int IVL_STEP_CYC = tsc_pkg::IVL_STEP_CYC,
   parameter int DISCH_CYC    = tsc_pkg::DISCH_HI_CYC
) (
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   input  wire logic                     wb_we_i,
   input  wire logic [tsc_pkg::ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic [31:0]              wb_dat_i,
   output logic [31:0]                   wb_dat_o,
   output logic                          wb_ack_o,
   input  wire logic                     wake_i,
   input  wire logic                     osc_ready_i,
   input  wire logic                     pll_locked_i,
   input  wire logic                     rf_on_i,
   input  wire logic                     reader_mode_i,
   output logic                          tx_reg_en_o,
   output logic                          tx_reg_ocp_en_o,
   output logic [7:0]                    amp_supply_code_o,
   output logic [7:0]                    boost_code_o,
   output logic [3:0]                    pll_ref_sel_o,
   output logic                          pll_ref_valid_o,
   output logic                          osc_recal_o,
   output logic                          pll_lock_req_o,
   output logic                          clk_err_o,
   output logic                          irq_o
);
   // ----------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------
   function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
      return (a < b) ? a : b;
   endfunction

   function automatic logic ref_ok(input logic [3:0] c);
      return (c <= tsc_pkg::REF_48M) || (c == tsc_pkg::REF_HFO)
             || (c == tsc_pkg::REF_XTAL);
   endfunction

   typedef enum logic [1:0] {DS_RUN, DS_HIGH, DS_LOW} tsc_disch_t;

   logic [1:0]           txreg_reg;
   logic [7:0]           amp_nom_reg;
   logic [7:0]           amp_rdr_reg;
   logic [7:0]           amp_card_reg;
   logic [7:0]           boost_reg;
   logic [7:0]           osc_cfg_reg;
   logic [7:0]           osc_tmo_reg;
   logic [7:0]           pll_ref_reg;
   logic [7:0]           retry_cfg_reg;
   logic [7:0]           disch_reg;
   logic [tsc_pkg::ST_W-1:0] status_reg;
   logic [tsc_pkg::ST_W-1:0] status_next;
   logic [tsc_pkg::ST_W-1:0] mask_reg;
   logic [tsc_pkg::ST_W-1:0] evt_vec;
   logic                 ack_reg;
   logic [31:0]          rdata_reg;
   logic [31:0]          rdata_next;
   logic [10:0]          idx;
   logic                 hit;
   logic                 wr0;
   logic                 rd_fire;
   tsc_disch_t           ds_reg;
   logic [15:0]          ds_cnt_reg;
   logic                 rf_prev_reg;
   logic                 disch_evt_reg;
   logic [7:0]           amp_reg;
   logic [7:0]           amp_limit;
   logic [7:0]           boost_out_reg;
   logic [3:0]           ref_sel_reg;
   logic                 ref_valid_reg;
   logic                 irq_reg;
   tsc_pkg::tsc_osc_cfg_t osc_cfg;
   tsc_pkg::tsc_evt_t    seq_evt;
   logic [1:0]           seq_state;
   logic [2:0]           seq_retry;

   // ----------------------------------------------------------
   // Wishbone slave
   // ----------------------------------------------------------
   assign idx     = wb_adr_i[tsc_pkg::ADR_W-1:2];
   assign hit     = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign wr0     = hit & wb_we_i & wb_sel_i[0];
   assign rd_fire = hit & ~wb_we_i;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack_reg <= 1'b0;
      else
         ack_reg <= hit;
   end

   always_comb
   begin
      rdata_next = 32'h0;
      unique case (idx)
         tsc_pkg::IDX_TXREG:    rdata_next[1:0] = txreg_reg;
         tsc_pkg::IDX_AMP_NOM:  rdata_next[7:0] = amp_nom_reg;
         tsc_pkg::IDX_AMP_RDR:  rdata_next[7:0] = amp_rdr_reg;
         tsc_pkg::IDX_AMP_CARD: rdata_next[7:0] = amp_card_reg;
         tsc_pkg::IDX_BOOST:    rdata_next[7:0] = boost_reg;
         tsc_pkg::IDX_OSC_CFG:  rdata_next[7:0] = osc_cfg_reg;
         tsc_pkg::IDX_OSC_TMO:  rdata_next[7:0] = osc_tmo_reg;
         tsc_pkg::IDX_PLL_REF:  rdata_next[7:0] = pll_ref_reg;
         tsc_pkg::IDX_RETRY:    rdata_next[7:0] = retry_cfg_reg;
         tsc_pkg::IDX_DISCH:    rdata_next[7:0] = disch_reg;
         tsc_pkg::IDX_STATUS:   rdata_next[tsc_pkg::ST_W-1:0] = status_reg;
         tsc_pkg::IDX_MASK:     rdata_next[tsc_pkg::ST_W-1:0] = mask_reg;
         tsc_pkg::IDX_STATE:    rdata_next[7:0] = {ds_reg, seq_retry, 1'b0, seq_state};
         default:               rdata_next = 32'h0;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rdata_reg <= 32'h0;
      else if (rd_fire)
         rdata_reg <= rdata_next;
      else if (ack_reg)
         rdata_reg <= 32'h0;
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;

   // ----------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         txreg_reg     <= tsc_pkg::RST_TXREG;
         amp_nom_reg   <= tsc_pkg::RST_BYTE;
         amp_rdr_reg   <= tsc_pkg::RST_BYTE;
         amp_card_reg  <= tsc_pkg::RST_BYTE;
         boost_reg     <= tsc_pkg::RST_BYTE;
         osc_cfg_reg   <= tsc_pkg::RST_BYTE;
         osc_tmo_reg   <= tsc_pkg::RST_BYTE;
         pll_ref_reg   <= tsc_pkg::RST_BYTE;
         retry_cfg_reg <= tsc_pkg::RST_BYTE;
         disch_reg     <= tsc_pkg::RST_DISCH;
         mask_reg      <= '0;
      end
      else if (wr0)
      begin
         unique case (idx)
            tsc_pkg::IDX_TXREG:    txreg_reg     <= wb_dat_i[1:0];
            tsc_pkg::IDX_AMP_NOM:  amp_nom_reg   <= wb_dat_i[7:0];
            tsc_pkg::IDX_AMP_RDR:  amp_rdr_reg   <= wb_dat_i[7:0];
            tsc_pkg::IDX_AMP_CARD: amp_card_reg  <= wb_dat_i[7:0];
            tsc_pkg::IDX_BOOST:    boost_reg     <= wb_dat_i[7:0];
            tsc_pkg::IDX_OSC_CFG:  osc_cfg_reg   <= wb_dat_i[7:0];
            tsc_pkg::IDX_OSC_TMO:  osc_tmo_reg   <= wb_dat_i[7:0];
            tsc_pkg::IDX_PLL_REF:  pll_ref_reg   <= wb_dat_i[7:0];
            tsc_pkg::IDX_RETRY:    retry_cfg_reg <= wb_dat_i[7:0];
            tsc_pkg::IDX_DISCH:    disch_reg     <= wb_dat_i[7:0];
            tsc_pkg::IDX_MASK:     mask_reg      <= wb_dat_i[tsc_pkg::ST_W-1:0];
            default:               mask_reg      <= mask_reg;
         endcase
      end
   end

   // ----------------------------------------------------------
   // Regulator controls
   // ----------------------------------------------------------
   assign tx_reg_en_o     = txreg_reg[tsc_pkg::TXREG_EN_BIT];
   assign tx_reg_ocp_en_o = txreg_reg[tsc_pkg::TXREG_OCP_BIT];

   // Mode maximum, then absolute ceiling
   assign amp_limit = min8(reader_mode_i ? amp_rdr_reg : amp_card_reg,
                           tsc_pkg::AMP_CODE_MAX);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         amp_reg <= tsc_pkg::AMP_CODE_MIN;
      else
      begin
         unique case (ds_reg)
            DS_HIGH: amp_reg <= tsc_pkg::AMP_CODE_MAX;
            DS_LOW:  amp_reg <= tsc_pkg::AMP_CODE_MIN;
            default: amp_reg <= min8(amp_nom_reg, amp_limit);
         endcase
      end
   end
   assign amp_supply_code_o = amp_reg;

   // Reserved boost codes leave the last valid level in place
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         boost_out_reg <= tsc_pkg::RST_BYTE;
      else if (boost_reg <= tsc_pkg::BOOST_CODE_MAX)
         boost_out_reg <= boost_reg;
   end
   assign boost_code_o = boost_out_reg;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ref_sel_reg   <= 4'h0;
         ref_valid_reg <= 1'b0;
      end
      else
      begin
         ref_sel_reg   <= pll_ref_reg[tsc_pkg::REF_MSB:0];
         ref_valid_reg <= ref_ok(pll_ref_reg[tsc_pkg::REF_MSB:0]);
      end
   end
   assign pll_ref_sel_o   = ref_sel_reg;
   assign pll_ref_valid_o = ref_valid_reg;

   // ----------------------------------------------------------
   // Fast discharge at field-off
   // ----------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      disch_evt_reg <= 1'b0;
      if (rst_i)
      begin
         ds_reg      <= DS_RUN;
         ds_cnt_reg  <= 16'h0;
         rf_prev_reg <= 1'b0;
      end
      else
      begin
         rf_prev_reg <= rf_on_i;
         unique case (ds_reg)
            DS_RUN:
            if (rf_prev_reg && !rf_on_i && disch_reg[tsc_pkg::DISCH_BIT])
            begin
               ds_reg     <= DS_HIGH;
               ds_cnt_reg <= 16'h0;
            end
            DS_HIGH:
            if (ds_cnt_reg == 16'(DISCH_CYC - 1))
            begin
               ds_reg        <= DS_LOW;
               disch_evt_reg <= 1'b1;
            end
            else
               ds_cnt_reg <= ds_cnt_reg + 16'h1;
            DS_LOW:
            if (rf_on_i)
               ds_reg <= DS_RUN;
            default:
               ds_reg <= DS_RUN;
         endcase
      end
   end

   // ----------------------------------------------------------
   // Start-up sequencer
   // ----------------------------------------------------------
   assign osc_cfg.recal_en  = osc_cfg_reg[tsc_pkg::RECAL_BIT];
   assign osc_cfg.timeout   = osc_tmo_reg;
   assign osc_cfg.max_retry = retry_cfg_reg[tsc_pkg::RETRY_MSB:tsc_pkg::RETRY_LSB];
   assign osc_cfg.interval  = retry_cfg_reg[tsc_pkg::IVL_MSB:tsc_pkg::IVL_LSB];

   tsc_lock_seq #(
      .STEP_CYC (OSC_STEP_CYC),
      .IVL_CYC  (IVL_STEP_CYC)
   ) u_seq (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .wake_i       (wake_i),
      .cfg_i        (osc_cfg),
      .osc_ready_i  (osc_ready_i),
      .pll_locked_i (pll_locked_i),
      .recal_o      (osc_recal_o),
      .lock_req_o   (pll_lock_req_o),
      .evt_o        (seq_evt),
      .state_o      (seq_state),
      .retry_o      (seq_retry)
   );

   // ----------------------------------------------------------
   // Status and interrupt
   // ----------------------------------------------------------
   always_comb
   begin
      evt_vec                     = '0;
      evt_vec[tsc_pkg::ST_CLKERR] = seq_evt.clk_err;
      evt_vec[tsc_pkg::ST_TMO]    = seq_evt.tmo;
      evt_vec[tsc_pkg::ST_LOCK]   = seq_evt.locked;
      evt_vec[tsc_pkg::ST_DISCH]  = disch_evt_reg;
      // New events win over the read clear
      status_next = evt_vec;
      if (!(rd_fire && idx == tsc_pkg::IDX_STATUS))
         status_next = status_next | status_reg;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         status_reg <= '0;
         irq_reg    <= 1'b0;
      end
      else
      begin
         status_reg <= status_next;
         irq_reg    <= |(status_next & mask_reg);
      end
   end
   assign irq_o     = irq_reg;
   assign clk_err_o = status_reg[tsc_pkg::ST_CLKERR];

   // ----------------------------------------------------------
   // Checks
   // ----------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   localparam int DISCH_LIM = DISCH_CYC + 2;

   property p_ocp;
      (wr0 && idx == tsc_pkg::IDX_TXREG) |=> (tx_reg_ocp_en_o == $past(wb_dat_i[1]));
   endproperty
   a_ocp: assert property (p_ocp) else $error("protection bit not applied");
   property p_reg_en;
      (wr0 && idx == tsc_pkg::IDX_TXREG) |=> (tx_reg_en_o == $past(wb_dat_i[0]));
   endproperty
   a_reg_en: assert property (p_reg_en) else $error("enable bit not applied");
   property p_amp_cap;
      amp_supply_code_o <= tsc_pkg::AMP_CODE_MAX;
   endproperty
   a_amp_cap: assert property (p_amp_cap) else $error("supply code above ceiling");
   property p_amp_mode;
      (ds_reg == DS_RUN) |=> (amp_supply_code_o <= (($past(reader_mode_i))
                              ? $past(amp_rdr_reg) : $past(amp_card_reg)));
   endproperty
   a_amp_mode: assert property (p_amp_mode) else $error("mode maximum exceeded");
   property p_boost;
      boost_code_o <= tsc_pkg::BOOST_CODE_MAX;
   endproperty
   a_boost: assert property (p_boost) else $error("reserved boost code out");
   property p_ref;
      pll_ref_valid_o |-> (pll_ref_sel_o != 4'h6 && pll_ref_sel_o <= tsc_pkg::REF_XTAL);
   endproperty
   a_ref: assert property (p_ref) else $error("reserved reference marked valid");
   property p_disch;
      (ds_reg == DS_RUN && rf_prev_reg && !rf_on_i && disch_reg[0])
         |=> ##1 (amp_supply_code_o == tsc_pkg::AMP_CODE_MAX)
         ##[1:DISCH_LIM] (amp_supply_code_o == tsc_pkg::AMP_CODE_MIN);
   endproperty
   a_disch: assert property (p_disch) else $error("discharge sequence wrong");
   property p_sticky;
      (clk_err_o && !(rd_fire && idx == tsc_pkg::IDX_STATUS)) |=> clk_err_o;
   endproperty
   a_sticky: assert property (p_sticky) else $error("clock error lost");

   c_lock:  cover property (seq_evt.locked);
   c_err:   cover property (seq_evt.clk_err ##[1:20] (rd_fire && idx == tsc_pkg::IDX_STATUS));
   c_disch: cover property (ds_reg == DS_HIGH ##[1:DISCH_LIM] ds_reg == DS_LOW);
endmodule

//--- test/tsc_top_tb.sv
// Purpose: Self-checking bench for tsc_top
// Assumes: Short timing parameters
// Notes:   Expected values come from bench integers
`timescale 1ns/1ps
module tsc_top_tb;
   logic        clk_i = 0, rst_i = 1, cyc = 0, we = 0, wake = 0, rdy = 1, lck = 0, rf = 1, rdr = 1;
   logic [12:0] adr = '0;
   logic [31:0] wd = '0, q, dat;
   logic        ack, txen, ocp, refv, recal, lreq, cerr, irq;
   logic [7:0]  amp, bst;
   logic [3:0]  rsel;
   int          err_count = 0, checked = 0, i, n, v, e, b = 0;
   int          m[int];
   int          ra[10] = '{2, 6, 7, 8, 9, 15, 16, 17, 18, 'h50d};
   always #12.5 clk_i = ~clk_i;
   tsc_top #(.OSC_STEP_CYC(8), .IVL_STEP_CYC(4), .DISCH_CYC(4)) tsc_top_i (.clk_i(clk_i),
      .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack), .wake_i(wake),
      .osc_ready_i(rdy), .pll_locked_i(lck), .rf_on_i(rf), .reader_mode_i(rdr),
      .tx_reg_en_o(txen), .tx_reg_ocp_en_o(ocp), .amp_supply_code_o(amp), .boost_code_o(bst),
      .pll_ref_sel_o(rsel), .pll_ref_valid_o(refv), .osc_recal_o(recal),
      .pll_lock_req_o(lreq), .clk_err_o(cerr), .irq_o(irq));
   task automatic test_done;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      checked++;
      if (s !== x)
      begin
         err_count++;
         $display("mismatch t=%0t seen %h exp %h", $time, s, x);
      end
   endtask
   task automatic wb(input logic w, input int a, input int d);
      @(posedge clk_i);
      cyc <= 1;
      we <= w;
      adr <= 13'(a * 4);
      wd <= d;
      n = 0;
      do @(posedge clk_i); while (ack !== 1 && ++n < 50);
      if (ack !== 1)
      begin
         err_count++;
         test_done;
      end
      q = dat;
      cyc <= 0;
   endtask
   task automatic amp_chk(input int mx);
      repeat (2) @(posedge clk_i);
      e = m[6] < mx ? m[6] : mx;
      chk(amp, e > 'h2a ? 'h2a : e);
   endtask
   task automatic wake_wait;
      wake <= 1;
      @(posedge clk_i);
      wake <= 0;
      n = 0;
      while (irq !== 1 && n++ < 300)
         @(posedge clk_i);
      if (n > 300)
      begin
         err_count++;
         test_done;
      end
   endtask
   // ----------------------------------------------------------
   // Stimulus
   // ----------------------------------------------------------
   initial
   begin
      void'($urandom(32'he550f24a));
      repeat (16) @(posedge clk_i);
      rst_i <= 0;
      for (int r = 0; r < 2; r++)
         foreach (ra[k])
         begin
            v = $urandom & 'hff;
            if (r == 0)
            begin
               wb(0, ra[k], 0);
               chk(q, ra[k] == 'h50d);
            end
            wb(1, ra[k], v);
            if (ra[k] == 2)
               v &= 3;
            if (ra[k] == 9 && v <= 'h1d)
               b = v;
            m[ra[k]] = v;
            wb(0, ra[k], 0);
            chk(q, v);
         end
      @(posedge clk_i);
      chk(txen, m[2] & 1);
      chk(ocp, m[2] >> 1);
      chk(bst, b);
      v = m[17] & 15;
      chk(rsel, v);
      chk(refv, v < 6 || v == 7 || v == 8);
      amp_chk(m[7]);
      rdr <= 0;
      amp_chk(m[8]);
      wb(1, 'h30, 'hff);
      wb(0, 'h30, 0);
      chk(q, 0);
      $display("test registers done");
      wb(1, 15, 1);
      wb(1, 18, 'h21);
      wb(1, 16, 'hff);
      wb(1, 'h21, 1);
      wb(0, 'h20, 0);
      wake <= 1;
      @(posedge clk_i);
      wake <= 0;
      n = 0;
      i = 0;
      v = 0;
      while (cerr !== 1 && n++ < 300)
      begin
         @(posedge clk_i);
         i += lreq === 1;
         v += recal === 1;
      end
      chk(v, 1);
      chk(i, 2);
      chk(cerr, 1);
      if (n > 300)
         test_done;
      repeat (2) @(posedge clk_i);
      chk(irq, 1);
      wb(1, 'h21, 0);
      repeat (2) @(posedge clk_i);
      chk(irq, 0);
      wb(1, 'h21, 1);
      wb(0, 'h20, 0);
      chk(q, 1);
      repeat (2) @(posedge clk_i);
      chk(cerr, 0);
      chk(irq, 0);
      $display("test lock done");
      wb(1, 6, 5);
      wb(1, 'h50d, 1);
      rf <= 0;
      n = 0;
      repeat (12)
      begin
         @(posedge clk_i);
         n += amp === 8'h2a;
      end
      chk(n, 4);
      chk(amp, 0);
      wb(0, 'h20, 0);
      chk(q, 8);
      rf <= 1;
      $display("test discharge done");
      wb(1, 16, 2);
      wb(1, 'h21, 2);
      rdy <= 0;
      wake_wait;
      chk(n, 2 * 8 + 3);
      wb(0, 'h20, 0);
      chk(q, 2);
      wb(1, 'h21, 4);
      rdy <= 1;
      lck <= 1;
      wake_wait;
      chk(irq, 1);
      wb(0, 'h20, 0);
      chk(q, 4);
      $display("test timeout and lock done");
      test_done;
   end
endmodule
